// ===== rtl/cps_pkg.sv
// Shared constants and types for the cell protection state control
package cps_pkg;

  // Delay clock
  localparam longint unsigned CLK_HZ = 64'd50000000;

  // Qualification delays, typical figures in their own units
  localparam longint unsigned OVERCHARGE_DELAY_MS = 64'd170;
  localparam longint unsigned OVERDISCH_DELAY_MS = 64'd40;
  localparam longint unsigned DSC_OC_DELAY_MS = 64'd10;
  localparam longint unsigned CHG_OC_DELAY_MS = 64'd10;
  localparam longint unsigned SHORT_DELAY_US = 64'd180;

  // Same delays as clock cycles
  localparam longint unsigned OVERCHARGE_DELAY_CYC =
    OVERCHARGE_DELAY_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned OVERDISCH_DELAY_CYC =
    OVERDISCH_DELAY_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned DSC_OC_DELAY_CYC =
    DSC_OC_DELAY_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned CHG_OC_DELAY_CYC =
    CHG_OC_DELAY_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned SHORT_DELAY_CYC =
    SHORT_DELAY_US * CLK_HZ / 64'd1000000;

  // Width of every qualification counter (holds the longest delay)
  localparam int TIMER_W = 24;

  // Positions of the comparator outcomes in the synchroniser vector
  localparam int IN_W = 13;
  localparam int IX_ABOVE_OC = 0;
  localparam int IX_BELOW_OCR = 1;
  localparam int IX_BELOW_OD = 2;
  localparam int IX_AT_ODR = 3;
  localparam int IX_DIODE_RISE = 4;
  localparam int IX_OVERCURRENT = 5;
  localparam int IX_SHORT = 6;
  localparam int IX_CHARGE_OC = 7;
  localparam int IX_PD_LEVEL = 8;
  localparam int IX_CHARGER = 9;
  localparam int IX_AT_CHG_DET = 10;
  localparam int IX_TEMP_HOT = 11;
  localparam int IX_TEMP_COOL = 12;

  // Protection states
  typedef enum logic [6:0] {
    ST_NORMAL = 7'h01,
    ST_OVERCHARGE = 7'h02,
    ST_OVERDISCH = 7'h04,
    ST_POWERDOWN = 7'h08,
    ST_DSC_OC = 7'h10,
    ST_CHG_OC = 7'h20,
    ST_OVERTEMP = 7'h40
  } cps_state_type;

  // Switch enables after reset: normal state
  localparam logic CHARGE_EN_RST = 1'h1;
  localparam logic DISCHARGE_EN_RST = 1'h1;

endpackage : cps_pkg

// ===== rtl/cps_qual_if.sv
// Condition and expiry pair between the controller and a qualification timer
`timescale 1ns/1ps
interface cps_qual_if;
  logic cond;
  logic done;
  modport timer (input cond, output done);
  modport ctrl (output cond, input done);
endinterface : cps_qual_if

// ===== rtl/cps_sync.sv
// Two-flop synchroniser for a vector of comparator outcomes
`timescale 1ns/1ps
module cps_sync
  import cps_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage is looked at from outside
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce)
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : cps_sync

// ===== rtl/cps_qual_timer.sv
// Qualification timer: done once its condition has held LIMIT cycles
`timescale 1ns/1ps
module cps_qual_timer
  import cps_pkg::*;
#(
  parameter int unsigned LIMIT = 1,
  parameter int W = TIMER_W
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Condition and expiry
  cps_qual_if.timer q
);

  logic [W-1:0] cnt_q;
  wire [W-1:0] cnt_d;
  wire at_limit;

  assign at_limit = (cnt_q == W'(LIMIT - 1));
  // Any drop of the condition starts the wait over
  assign cnt_d = !q.cond ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
  assign q.done = q.cond && at_limit;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (ce)
      cnt_q <= cnt_d;
  end

  chk_timer_restart: assert property (@(posedge clock) disable iff (!reset_n)
    ce && !q.cond |=> cnt_q == '0 && !q.done)
    else $error("timer did not restart after its condition dropped");

endmodule : cps_qual_timer

// ===== rtl/cps_protect_ctrl.sv
// Protection state control: qualifies faults and drives the switch enables
`timescale 1ns/1ps
module cps_protect_ctrl
  import cps_pkg::*;
#(
  parameter int unsigned OVERCHARGE_CYC = 32'(OVERCHARGE_DELAY_CYC),
  parameter int unsigned OVERDISCH_CYC = 32'(OVERDISCH_DELAY_CYC),
  parameter int unsigned DSC_OC_CYC = 32'(DSC_OC_DELAY_CYC),
  parameter int unsigned CHG_OC_CYC = 32'(CHG_OC_DELAY_CYC),
  parameter int unsigned SHORT_CYC = 32'(SHORT_DELAY_CYC)
)
(
  // Clock, reset and enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Cell voltage comparators
  input wire logic cell_above_overcharge,
  input wire logic cell_below_overcharge_release,
  input wire logic cell_below_overdischarge,
  input wire logic cell_at_overdischarge_release,
  // Load sense pin comparators
  input wire logic sense_diode_rise,
  input wire logic sense_overcurrent,
  input wire logic sense_short,
  input wire logic sense_charge_overcurrent,
  input wire logic sense_powerdown_level,
  input wire logic sense_charger_attached,
  input wire logic sense_at_charger_detect,
  // Die temperature comparators
  input wire logic temp_hot,
  input wire logic temp_cool,
  // Switch gates and status
  output logic charge_en,
  output logic discharge_en,
  output logic sense_pullup_en,
  output logic powerdown,
  output logic [6:0] state_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  wire [IN_W-1:0] raw_in;
  wire [IN_W-1:0] sync_in;

  assign raw_in[IX_ABOVE_OC] = cell_above_overcharge;
  assign raw_in[IX_BELOW_OCR] = cell_below_overcharge_release;
  assign raw_in[IX_BELOW_OD] = cell_below_overdischarge;
  assign raw_in[IX_AT_ODR] = cell_at_overdischarge_release;
  assign raw_in[IX_DIODE_RISE] = sense_diode_rise;
  assign raw_in[IX_OVERCURRENT] = sense_overcurrent;
  assign raw_in[IX_SHORT] = sense_short;
  assign raw_in[IX_CHARGE_OC] = sense_charge_overcurrent;
  assign raw_in[IX_PD_LEVEL] = sense_powerdown_level;
  assign raw_in[IX_CHARGER] = sense_charger_attached;
  assign raw_in[IX_AT_CHG_DET] = sense_at_charger_detect;
  assign raw_in[IX_TEMP_HOT] = temp_hot;
  assign raw_in[IX_TEMP_COOL] = temp_cool;

  // Comparators are asynchronous to the delay clock
  cps_sync #(
    .W(IN_W)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .din(raw_in),
    .dout(sync_in)
  );

  wire above_oc_s;
  wire below_ocr_s;
  wire below_od_s;
  wire at_odr_s;
  wire diode_s;
  wire ocur_s;
  wire short_s;
  wire chg_oc_s;
  wire pd_level_s;
  wire charger_s;
  wire at_chg_det_s;
  wire hot_s;
  wire cool_s;

  assign above_oc_s = sync_in[IX_ABOVE_OC];
  assign below_ocr_s = sync_in[IX_BELOW_OCR];
  assign below_od_s = sync_in[IX_BELOW_OD];
  assign at_odr_s = sync_in[IX_AT_ODR];
  assign diode_s = sync_in[IX_DIODE_RISE];
  assign ocur_s = sync_in[IX_OVERCURRENT];
  assign short_s = sync_in[IX_SHORT];
  assign chg_oc_s = sync_in[IX_CHARGE_OC];
  assign pd_level_s = sync_in[IX_PD_LEVEL];
  assign charger_s = sync_in[IX_CHARGER];
  assign at_chg_det_s = sync_in[IX_AT_CHG_DET];
  assign hot_s = sync_in[IX_TEMP_HOT];
  assign cool_s = sync_in[IX_TEMP_COOL];

  ////////////////////////////////////////////////////////////////////////////
  // State decode

  cps_state_type state_q;
  cps_state_type state_d;
  logic load_pend_q;

  wire in_normal;
  wire in_overcharge;
  wire in_overdisch;
  wire in_powerdown;
  wire in_overtemp;

  assign in_normal = (state_q == ST_NORMAL);
  assign in_overcharge = (state_q == ST_OVERCHARGE);
  assign in_overdisch = (state_q == ST_OVERDISCH);
  assign in_powerdown = (state_q == ST_POWERDOWN);
  assign in_overtemp = (state_q == ST_OVERTEMP);

  ////////////////////////////////////////////////////////////////////////////
  // Qualification timers

  cps_qual_if ovc_if ();
  cps_qual_if ovd_if ();
  cps_qual_if doc_if ();
  cps_qual_if coc_if ();
  cps_qual_if shc_if ();

  assign ovc_if.cond = in_normal && above_oc_s;
  assign ovd_if.cond = in_normal && below_od_s;
  // No discharge overcurrent while the cell sits above overcharge
  assign doc_if.cond = in_normal && ocur_s && !above_oc_s;
  assign coc_if.cond = in_normal && chg_oc_s;
  // Short works in the normal and overcharge states, whatever the cell does
  assign shc_if.cond = (in_normal || in_overcharge) && short_s;

  cps_qual_timer #(
    .LIMIT(OVERCHARGE_CYC)
  ) u_ovc_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .q(ovc_if.timer)
  );

  cps_qual_timer #(
    .LIMIT(OVERDISCH_CYC)
  ) u_ovd_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .q(ovd_if.timer)
  );

  cps_qual_timer #(
    .LIMIT(DSC_OC_CYC)
  ) u_doc_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .q(doc_if.timer)
  );

  cps_qual_timer #(
    .LIMIT(CHG_OC_CYC)
  ) u_coc_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .q(coc_if.timer)
  );

  cps_qual_timer #(
    .LIMIT(SHORT_CYC)
  ) u_shc_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .q(shc_if.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Release conditions

  wire load_now;
  wire load_seen;
  wire ovc_release;
  wire odc_release;
  wire ocur_clear;

  // A load counts only if the sense pin also clears the overcurrent level
  assign load_now = in_overcharge && diode_s && ocur_s;
  assign load_seen = load_pend_q || load_now;
  // A pending load waits for the cell to come down to the threshold
  assign ovc_release = below_ocr_s || (load_seen && !above_oc_s);
  // A high sense pin at charger attach raises the bar to the release level
  assign odc_release = at_chg_det_s ? at_odr_s : !below_od_s;
  assign ocur_clear = !ocur_s && !short_s;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_d = state_q;
    if (hot_s && !in_overtemp)
      state_d = ST_OVERTEMP;
    else
    begin
      unique case (state_q)
        ST_NORMAL:
        begin
          if (shc_if.done || doc_if.done)
            state_d = ST_DSC_OC;
          else if (coc_if.done)
            state_d = ST_CHG_OC;
          else if (ovd_if.done)
            state_d = ST_OVERDISCH;
          else if (ovc_if.done)
            state_d = ST_OVERCHARGE;
        end
        ST_OVERCHARGE:
        begin
          if (shc_if.done)
            state_d = ST_DSC_OC;
          else if (ovc_release)
            state_d = ST_NORMAL;
        end
        ST_OVERDISCH:
        begin
          if (odc_release)
            state_d = ST_NORMAL;
          else if (pd_level_s)
            state_d = ST_POWERDOWN;
        end
        ST_POWERDOWN:
        begin
          if (charger_s)
            state_d = ST_OVERDISCH;
        end
        ST_DSC_OC:
        begin
          if (ocur_clear)
            state_d = ST_NORMAL;
        end
        ST_CHG_OC:
        begin
          if (!chg_oc_s)
            state_d = ST_NORMAL;
        end
        ST_OVERTEMP:
        begin
          if (cool_s)
            state_d = ST_NORMAL;
        end
        default:
          state_d = ST_NORMAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output decode and registers

  wire charge_en_d;
  wire discharge_en_d;
  wire pullup_d;
  wire powerdown_d;
  wire load_pend_d;

  assign charge_en_d = !(state_d == ST_OVERCHARGE || state_d == ST_CHG_OC ||
    state_d == ST_OVERTEMP);
  assign discharge_en_d = !(state_d == ST_OVERDISCH ||
    state_d == ST_POWERDOWN || state_d == ST_DSC_OC ||
    state_d == ST_OVERTEMP);
  assign pullup_d = (state_d == ST_OVERDISCH) ||
    (state_d == ST_POWERDOWN);
  assign powerdown_d = (state_d == ST_POWERDOWN);
  // Pending load is forgotten once overcharge is left
  assign load_pend_d = (state_d == ST_OVERCHARGE) && load_seen;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_NORMAL;
      load_pend_q <= 1'h0;
      charge_en <= CHARGE_EN_RST;
      discharge_en <= DISCHARGE_EN_RST;
      sense_pullup_en <= 1'h0;
      powerdown <= 1'h0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      load_pend_q <= load_pend_d;
      charge_en <= charge_en_d;
      discharge_en <= discharge_en_d;
      sense_pullup_en <= pullup_d;
      powerdown <= powerdown_d;
    end
  end

  assign state_code = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_normal_both_on: assert property (
    in_normal |-> charge_en && discharge_en)
    else $error("normal state without both switches on");

  chk_overcharge_entry: assert property (
    ce && in_normal && ovc_if.done && !hot_s && !shc_if.done &&
    !doc_if.done && !coc_if.done && !ovd_if.done
    |=> in_overcharge && !charge_en)
    else $error("qualified overcharge did not cut charging");

  chk_overcharge_release: assert property (
    ce && in_overcharge && below_ocr_s && !hot_s && !shc_if.done
    |=> in_normal && charge_en)
    else $error("overcharge not released below release level");

  chk_load_waits_cell: assert property (
    ce && in_overcharge && above_oc_s && !below_ocr_s
    |=> !in_normal)
    else $error("load released overcharge with cell still high");

  chk_load_low_sense: assert property (
    ce && in_overcharge && !load_pend_q && !ocur_s && !below_ocr_s
    |=> !in_normal)
    else $error("load with low sense pin released overcharge");

  chk_ocur_inhibit: assert property (
    in_normal && above_oc_s && !shc_if.done |=> state_q != ST_DSC_OC)
    else $error("discharge overcurrent qualified above overcharge");

  chk_short_cut: assert property (
    ce && shc_if.done && !hot_s |=> state_q == ST_DSC_OC && !discharge_en)
    else $error("short circuit did not cut discharge");

  chk_chg_ocur_cause: assert property (
    $rose(state_q == ST_CHG_OC) |-> $past(coc_if.done) && !charge_en)
    else $error("charge overcurrent entered without qualification");

  chk_od_entry_cause: assert property (
    $rose(in_overdisch) && $past(in_normal) |-> $past(ovd_if.done))
    else $error("overdischarge entered without qualification");

  chk_pullup_od: assert property (
    in_overdisch || in_powerdown |-> sense_pullup_en && !discharge_en)
    else $error("pull-up missing or discharge on in overdischarge");

  chk_pd_exit: assert property (
    ce && in_powerdown && charger_s && !hot_s
    |=> in_overdisch && !discharge_en && !powerdown)
    else $error("charger did not wake from power-down");

  chk_od_recover: assert property (
    ce && in_overdisch && !at_chg_det_s && !below_od_s && !hot_s
    |=> in_normal ##0 discharge_en)
    else $error("overdischarge not released at threshold");

  chk_od_high_sense: assert property (
    ce && in_overdisch && at_chg_det_s && !at_odr_s |=> !in_normal)
    else $error("released overdischarge below release level");

  chk_overtemp_trip: assert property (
    ce && hot_s |=> in_overtemp && !charge_en && !discharge_en)
    else $error("overtemperature did not open both switches");

endmodule : cps_protect_ctrl

// ===== testbench/cps_analog_model.sv
// Comparator and sense pull-up model of the analog front end
`timescale 1ns/1ps
module cps_analog_model
#(
  parameter int OV_MV = 4000,
  parameter int OVR_MV = 3900,
  parameter int OD_MV = 3000,
  parameter int ODR_MV = 3200,
  parameter int DIODE_MV = 700,
  parameter int OC_MV = 800,
  parameter int SHORT_MV = 1400,
  parameter int PD_MV = 1500,
  parameter int CHG_DIFF_MV = 1300,
  parameter int CHA_MV = -700,
  parameter int CHOC_MV = -100,
  parameter int HOT_C = 150,
  parameter int COOL_C = 110
)
(
  // Levels set by the bench
  input wire logic signed [15:0] cell_mv,
  input wire logic signed [15:0] sense_mv,
  input wire logic signed [15:0] temp_c,
  input wire logic load_on,
  // From the controller
  input wire logic sense_pullup_en,
  // Comparator outcomes
  output logic cell_above_overcharge,
  output logic cell_below_overcharge_release,
  output logic cell_below_overdischarge,
  output logic cell_at_overdischarge_release,
  output logic sense_diode_rise,
  output logic sense_overcurrent,
  output logic sense_short,
  output logic sense_charge_overcurrent,
  output logic sense_powerdown_level,
  output logic sense_charger_attached,
  output logic sense_at_charger_detect,
  output logic temp_hot,
  output logic temp_cool
);
  logic signed [15:0] vm;

  // With nothing on the pack the pull-up lifts the pin to the cell
  assign vm = (sense_pullup_en && !load_on) ? cell_mv : sense_mv;
  assign cell_above_overcharge = cell_mv > OV_MV;
  assign cell_below_overcharge_release = cell_mv < OVR_MV;
  assign cell_below_overdischarge = cell_mv < OD_MV;
  assign cell_at_overdischarge_release = cell_mv >= ODR_MV;
  assign sense_diode_rise = vm >= DIODE_MV;
  assign sense_overcurrent = vm >= OC_MV;
  assign sense_short = vm >= SHORT_MV;
  assign sense_charge_overcurrent = vm <= CHOC_MV;
  assign sense_powerdown_level = vm > PD_MV;
  assign sense_charger_attached = (cell_mv - vm) >= CHG_DIFF_MV;
  assign sense_at_charger_detect = vm >= CHA_MV;
  assign temp_hot = temp_c >= HOT_C;
  assign temp_cool = temp_c <= COOL_C;
endmodule : cps_analog_model

// ===== testbench/test_cell_protection_state_control.sv
// Self-checking bench for the protection state control
`timescale 1ns/1ps
module test_cell_protection_state_control;
  import cps_pkg::*;
  localparam int OC_L = 12;
  localparam int OD_L = 10;
  localparam int DOC_L = 8;
  localparam int COC_L = 6;
  localparam int SC_L = 4;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic load_on = 1'b1;
  logic signed [15:0] cell_mv = 16'sd3700;
  logic signed [15:0] sense_mv = 16'sd0;
  logic signed [15:0] temp_c = 16'sd25;
  logic c_ov, c_ovr, c_od, c_odr, s_dio, s_oc, s_sc, s_coc, s_pd, s_chg, s_cha;
  logic t_hot, t_cool, charge_en, discharge_en, sense_pullup_en, powerdown;
  logic [6:0] state_code;
  int failures = 0;
  int tests_run = 0;

  always #10 clock = ~clock;

  cps_protect_ctrl #(.OVERCHARGE_CYC(OC_L), .OVERDISCH_CYC(OD_L),
    .DSC_OC_CYC(DOC_L), .CHG_OC_CYC(COC_L), .SHORT_CYC(SC_L)) uut (
    .clock(clock), .reset_n(reset_n), .ce(ce),
    .cell_above_overcharge(c_ov), .cell_below_overcharge_release(c_ovr),
    .cell_below_overdischarge(c_od), .cell_at_overdischarge_release(c_odr),
    .sense_diode_rise(s_dio), .sense_overcurrent(s_oc),
    .sense_short(s_sc), .sense_charge_overcurrent(s_coc),
    .sense_powerdown_level(s_pd), .sense_charger_attached(s_chg),
    .sense_at_charger_detect(s_cha), .temp_hot(t_hot), .temp_cool(t_cool),
    .charge_en(charge_en), .discharge_en(discharge_en),
    .sense_pullup_en(sense_pullup_en), .powerdown(powerdown),
    .state_code(state_code));

  cps_analog_model analog (
    .cell_mv(cell_mv), .sense_mv(sense_mv), .temp_c(temp_c),
    .load_on(load_on), .sense_pullup_en(sense_pullup_en),
    .cell_above_overcharge(c_ov), .cell_below_overcharge_release(c_ovr),
    .cell_below_overdischarge(c_od), .cell_at_overdischarge_release(c_odr),
    .sense_diode_rise(s_dio), .sense_overcurrent(s_oc),
    .sense_short(s_sc), .sense_charge_overcurrent(s_coc),
    .sense_powerdown_level(s_pd), .sense_charger_attached(s_chg),
    .sense_at_charger_detect(s_cha), .temp_hot(t_hot), .temp_cool(t_cool));

  ////////////////////////////////////////////////////////////////////////////
  // Inputs always move 2 ns after the edge, clear of the sampling instant
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  task automatic chk(input string name, input logic [6:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Expected {charge_en, discharge_en} for each state
  function automatic logic [1:0] exp_en(input logic [6:0] st);
    case (st)
      ST_OVERCHARGE, ST_CHG_OC: return 2'h1;
      ST_OVERDISCH, ST_POWERDOWN, ST_DSC_OC: return 2'h2;
      ST_OVERTEMP: return 2'h0;
      default: return 2'h3;
    endcase
  endfunction : exp_en

  task automatic chk_state(input logic [6:0] exp);
    chk("state", state_code, exp);
    chk("enables", {5'h0, charge_en, discharge_en}, {5'h0, exp_en(exp)});
  endtask : chk_state

  task automatic wait_state(input logic [6:0] exp, input int bound);
    int i;
    for (i = 0; i < bound && state_code !== exp; i++)
      tick(1);
    if (state_code !== exp)
    begin
      chk("wait", state_code, exp);
      end_of_test();
    end
    chk_state(exp);
  endtask : wait_state

  task automatic end_of_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    void'($urandom(23));
    tick(20);
    reset_n = 1'b1;
    chk_state(ST_NORMAL);
    // An interrupted overcharge must count its full delay again
    cell_mv = 16'sd4100;
    tick(OC_L - 2);
    cell_mv = 16'sd3950;
    tick(4);
    cell_mv = 16'sd4100;
    tick(OC_L + 1);
    chk_state(ST_NORMAL);
    tick(1);
    chk_state(ST_OVERCHARGE);
    sense_mv = 16'sd700;
    tick(6);
    sense_mv = 16'sd0;
    tick(4);
    chk_state(ST_OVERCHARGE);
    sense_mv = 16'sd900;
    tick(3);
    sense_mv = 16'sd0;
    tick(4);
    chk_state(ST_OVERCHARGE);
    cell_mv = 16'sd3950;
    wait_state(ST_NORMAL, 4);
    cell_mv = 16'sd4100;
    wait_state(ST_OVERCHARGE, OC_L + 3);
    sense_mv = 16'sd1450;
    wait_state(ST_DSC_OC, SC_L + 4);
    sense_mv = 16'sd0;
    wait_state(ST_NORMAL, 4);
    wait_state(ST_OVERCHARGE, OC_L + 3);
    cell_mv = 16'sd3800;
    wait_state(ST_NORMAL, 4);
    // Overcurrent is blind while the cell is above overcharge
    sense_mv = 16'sd900;
    cell_mv = 16'sd4100;
    tick(10);
    chk_state(ST_NORMAL);
    cell_mv = 16'sd3700;
    wait_state(ST_DSC_OC, DOC_L + 4);
    sense_mv = 16'sd0;
    wait_state(ST_NORMAL, 4);
    sense_mv = -16'sd200;
    wait_state(ST_CHG_OC, COC_L + 4);
    sense_mv = 16'sd0;
    wait_state(ST_NORMAL, 4);
    // Overdischarge, power-down and charger release
    cell_mv = 16'sd2000;
    load_on = 1'b0;
    wait_state(ST_OVERDISCH, OD_L + 4);
    chk("pullup", {6'h0, sense_pullup_en}, 7'h1);
    wait_state(ST_POWERDOWN, 5);
    chk("powerdown", {6'h0, powerdown}, 7'h1);
    load_on = 1'b1;
    // Pin stays above the charger detect level: release level needed
    sense_mv = -16'sd300;
    wait_state(ST_OVERDISCH, 4);
    cell_mv = 16'sd3100;
    tick(6);
    chk_state(ST_OVERDISCH);
    sense_mv = -16'sd900;
    wait_state(ST_NORMAL, 4);
    sense_mv = 16'sd0;
    cell_mv = 16'sd3700;
    // A frozen clock enable holds every decision
    ce = 1'b0;
    temp_c = 16'sd150;
    tick(8);
    chk_state(ST_NORMAL);
    ce = 1'b1;
    wait_state(ST_OVERTEMP, 4);
    temp_c = 16'sd130;
    tick(6);
    chk_state(ST_OVERTEMP);
    temp_c = 16'sd110;
    wait_state(ST_NORMAL, 4);
    // Random short overcharge bursts never qualify
    repeat (20)
    begin
      n = $urandom_range(OC_L - 3, 1);
      cell_mv = 16'($urandom_range(4300, 4001));
      temp_c = 16'($urandom_range(149, 111));
      tick(n);
      cell_mv = 16'sd3950;
      tick(4);
      chk_state(ST_NORMAL);
    end
    chk_state(ST_NORMAL);
    end_of_test();
  end
endmodule : test_cell_protection_state_control
